// ---- can_mbs_pkg.sv ----
// Package for the CAN mask, receive buffer status and transmit control block
package can_mbs_pkg;
   localparam int NUM_MASKS = 3;
   localparam int NUM_BUFS  = 32;
   localparam int NUM_CTRL  = 4;
   // Register byte addresses
   localparam logic [7:0] MASK_BASE_ADDR  = 8'h00;
   localparam logic [7:0] FULL_LO_ADDR    = 8'h20;
   localparam logic [7:0] FULL_HI_ADDR    = 8'h24;
   localparam logic [7:0] OVF_LO_ADDR     = 8'h28;
   localparam logic [7:0] OVF_HI_ADDR     = 8'h2C;
   localparam logic [7:0] CTRL_BASE_ADDR  = 8'h30;
   // Standard mask word fields
   localparam int SID_MSB   = 15;
   localparam int SID_LSB   = 5;
   localparam int MODE_BIT  = 3;
   localparam int EXT_HI_MSB = 1;
   // Control byte fields
   localparam int DIR_BIT   = 7;
   localparam int ABT_BIT   = 6;
   localparam int LARB_BIT  = 5;
   localparam int ERR_BIT   = 4;
   localparam int REQ_BIT   = 3;
   localparam int RTR_BIT   = 2;
   localparam logic [15:0] STD_MASK_WMASK = 16'hFFEB;
   localparam logic [7:0]  CTRL_WMASK     = 8'h8F;
   localparam logic [1:0]  NO_MASK_SEL    = 2'b11;
   localparam logic [1:0]  BRESP_OKAY     = 2'b00;
   localparam logic [1:0]  BRESP_DECERR   = 2'b11;

   typedef struct packed {
      logic [15:0] std_w;
      logic [15:0] ext_w;
   } mask_set_t;

   typedef struct packed {
      logic        dir;
      logic        aborted;
      logic        arb_lost;
      logic        bus_err;
      logic        req;
      logic        rtr_en;
      logic [1:0]  prio;
   } buf_ctrl_t;

   // Identifier pattern of a frame or a filter: 11-bit standard + 18-bit extended
   typedef struct packed {
      logic        ext;
      logic [10:0] sid;
      logic [17:0] eid;
   } can_id_t;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRSP = 3'b010,
      BUS_RRSP = 3'b100
   } bus_state_t;
endpackage

// ---- can_mbs.sv ----
// CAN acceptance masks, receive buffer flags and transmit buffer control
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module can_mbs
   import can_mbs_pkg::*;
#(
   parameter int NBUF = NUM_BUFS
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Acceptance check from the protocol engine
   input  wire can_id_t     frame_id,
   input  wire can_id_t     filter_id,
   input  wire logic [1:0]  filter_mask_source,
   output logic             filter_accept,
   // Receive store events
   input  wire logic        rx_store,
   input  wire logic [4:0]  rx_store_buf,
   input  wire logic        rx_remote,
   input  wire logic [4:0]  rx_remote_buf,
   // Transmit status events for the buffer in flight
   input  wire logic        tx_done,
   input  wire logic        tx_abort_done,
   input  wire logic        tx_arb_lost,
   input  wire logic        tx_bus_error,
   input  wire logic [2:0]  tx_event_buf,
   // Transmit scheduling
   output logic             tx_pending,
   output logic [2:0]       tx_next_buf,
   output logic [7:0]       tx_abort_req,
   output logic [7:0]       buffer_direction_select
);
   // Message contents are kept in DMA memory; only masks, flags and control live here
   typedef struct packed {
      bus_state_t            st;
      logic                  aw_got;
      logic                  w_got;
      logic [7:0]            awaddr;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic [1:0]            bresp;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      mask_set_t [2:0]       masks;
      logic [31:0]           full;
      logic [31:0]           ovf;
      buf_ctrl_t [7:0]       ctrl;
      logic [7:0]            abort_req;
      logic                  acc;
      logic                  pend;
      logic [2:0]            nbuf;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // Flag words are laid out for exactly 32 buffers; the control decode covers buffers 0 to 7
   if (NBUF != NUM_BUFS) begin : g_nbuf_check
      $error("NBUF must be 32");
   end

   logic [31:0]  mask_sel;
   logic         sid_eq;
   logic         all_eq;
   logic         wr_go;
   logic [31:0]  wmask;
   logic [31:0]  wval;
   logic [31:0]  rval;
   logic         rhit;
   logic         whit;
   logic [2:0]   widx;
   logic [2:0]   ridx;
   logic [3:0]   best_pri;
   buf_ctrl_t    cb;

   always_comb begin
      s_nxt = s_r;
      mask_sel = '0;
      sid_eq = 1'b0;
      all_eq = 1'b0;
      wr_go = 1'b0;
      wmask = '0;
      wval = '0;
      rval = '0;
      rhit = 1'b0;
      whit = 1'b0;
      widx = '0;
      ridx = '0;
      best_pri = '0;
      cb = '0;

      // Acceptance: mask one compares, zero is don't-care
      if (filter_mask_source == NO_MASK_SEL) begin
         mask_sel = 32'hFFFF_FFFF;
      end else begin
         mask_sel = {s_r.masks[filter_mask_source].std_w,
                     s_r.masks[filter_mask_source].ext_w};
      end
      sid_eq = ((frame_id.sid ^ filter_id.sid) & mask_sel[16 + SID_LSB +: 11]) == '0;
      all_eq = sid_eq && (((frame_id.eid ^ filter_id.eid)
               & {mask_sel[16 + EXT_HI_MSB -: 2], mask_sel[15:0]}) == '0);
      if (filter_mask_source != NO_MASK_SEL && mask_sel[16 + MODE_BIT]) begin
         s_nxt.acc = (frame_id.ext == filter_id.ext) &&
                     (filter_id.ext ? all_eq : sid_eq);
      end else begin
         s_nxt.acc = frame_id.ext ? all_eq : sid_eq;
      end

      // Transmit status events for the buffer in flight
      s_nxt.abort_req = s_r.abort_req;
      if (tx_done) begin
         s_nxt.ctrl[tx_event_buf].req = 1'b0;
         s_nxt.abort_req[tx_event_buf] = 1'b0;
      end
      if (tx_abort_done) begin
         s_nxt.ctrl[tx_event_buf].aborted = 1'b1;
         // Dropping the request here keeps an aborted buffer out of the scheduler
         s_nxt.ctrl[tx_event_buf].req = 1'b0;
         s_nxt.abort_req[tx_event_buf] = 1'b0;
      end
      if (tx_arb_lost) begin
         s_nxt.ctrl[tx_event_buf].arb_lost = 1'b1;
      end
      if (tx_bus_error) begin
         s_nxt.ctrl[tx_event_buf].bus_err = 1'b1;
      end

      // AXI4-Lite slave: one write or one read at a time, write first
      s_axi_awready = (s_r.st == BUS_IDLE) && !s_r.aw_got;
      s_axi_wready  = (s_r.st == BUS_IDLE) && !s_r.w_got;
      s_axi_arready = (s_r.st == BUS_IDLE) && !s_r.aw_got && !s_r.w_got
                      && !s_axi_awvalid && !s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end

      case (s_r.st)
         BUS_IDLE: begin
            if (s_r.aw_got && s_r.w_got) begin
               wr_go = 1'b1;
               s_nxt.aw_got = 1'b0;
               s_nxt.w_got = 1'b0;
               s_nxt.st = BUS_WRSP;
            end else if (s_axi_arvalid && s_axi_arready) begin
               s_nxt.st = BUS_RRSP;
               s_nxt.rresp = BRESP_OKAY;
               if (s_axi_araddr < FULL_LO_ADDR) begin
                  ridx = s_axi_araddr[5:3];
                  if (ridx < 3'(NUM_MASKS)) begin
                     rhit = 1'b1;
                     rval = {16'h0000, s_axi_araddr[2] ? s_r.masks[ridx].ext_w
                                                        : s_r.masks[ridx].std_w};
                  end
               end else if (s_axi_araddr == FULL_LO_ADDR) begin
                  rhit = 1'b1;
                  rval = {16'h0000, s_r.full[15:0]};
               end else if (s_axi_araddr == FULL_HI_ADDR) begin
                  rhit = 1'b1;
                  rval = {16'h0000, s_r.full[31:16]};
               end else if (s_axi_araddr == OVF_LO_ADDR) begin
                  rhit = 1'b1;
                  rval = {16'h0000, s_r.ovf[15:0]};
               end else if (s_axi_araddr == OVF_HI_ADDR) begin
                  rhit = 1'b1;
                  rval = {16'h0000, s_r.ovf[31:16]};
               end else if (s_axi_araddr >= CTRL_BASE_ADDR && s_axi_araddr < 8'h40) begin
                  ridx = {s_axi_araddr[3:2], 1'b0};
                  rhit = 1'b1;
                  rval = {16'h0000, s_r.ctrl[ridx + 3'd1], s_r.ctrl[ridx]};
               end
               s_nxt.rdata = rhit ? rval : 32'h0000_0000;
               s_nxt.rresp = rhit ? BRESP_OKAY : BRESP_DECERR;
            end
         end
         BUS_WRSP: begin
            if (s_axi_bready) begin
               s_nxt.st = BUS_IDLE;
            end
         end
         BUS_RRSP: begin
            if (s_axi_rready) begin
               s_nxt.st = BUS_IDLE;
            end
         end
         default: begin
            s_nxt.st = BUS_IDLE;
         end
      endcase

      // Register writes; only the low 16 bits hold data
      wmask = {16'h0000, {8{s_r.wstrb[1]}}, {8{s_r.wstrb[0]}}};
      wval = s_r.wdata;
      if (wr_go) begin
         s_nxt.bresp = BRESP_OKAY;
         if (s_r.awaddr < FULL_LO_ADDR && s_r.awaddr[5:3] < 3'(NUM_MASKS)) begin
            widx = s_r.awaddr[5:3];
            whit = 1'b1;
            if (s_r.awaddr[2]) begin
               s_nxt.masks[widx].ext_w = (s_r.masks[widx].ext_w & ~wmask[15:0])
                                         | (wval[15:0] & wmask[15:0]);
            end else begin
               s_nxt.masks[widx].std_w = (s_r.masks[widx].std_w & ~wmask[15:0])
                                         | (wval[15:0] & wmask[15:0] & STD_MASK_WMASK);
            end
         end else if (s_r.awaddr == FULL_LO_ADDR || s_r.awaddr == FULL_HI_ADDR) begin
            whit = 1'b1;
            if (s_r.awaddr[2]) begin
               s_nxt.full[31:16] = s_r.full[31:16] & (wval[15:0] | ~wmask[15:0]);
            end else begin
               s_nxt.full[15:0] = s_r.full[15:0] & (wval[15:0] | ~wmask[15:0]);
            end
         end else if (s_r.awaddr == OVF_LO_ADDR || s_r.awaddr == OVF_HI_ADDR) begin
            whit = 1'b1;
            if (s_r.awaddr[2]) begin
               s_nxt.ovf[31:16] = s_r.ovf[31:16] & (wval[15:0] | ~wmask[15:0]);
            end else begin
               s_nxt.ovf[15:0] = s_r.ovf[15:0] & (wval[15:0] | ~wmask[15:0]);
            end
         end else if (s_r.awaddr >= CTRL_BASE_ADDR && s_r.awaddr < 8'h40) begin
            whit = 1'b1;
            for (int b = 0; b < 2; b++) begin
               widx = {s_r.awaddr[3:2], 1'b0} + 3'(b);
               if (s_r.wstrb[b]) begin
                  cb = buf_ctrl_t'(wval[8*b +: 8]);
                  s_nxt.ctrl[widx].dir = cb.dir;
                  s_nxt.ctrl[widx].rtr_en = cb.rtr_en;
                  s_nxt.ctrl[widx].prio = cb.prio;
                  if (cb.req && !s_r.ctrl[widx].req) begin
                     s_nxt.ctrl[widx].req = 1'b1;
                     s_nxt.ctrl[widx].aborted = 1'b0;
                     s_nxt.ctrl[widx].arb_lost = 1'b0;
                     s_nxt.ctrl[widx].bus_err = 1'b0;
                  end else if (!cb.req && s_r.ctrl[widx].req) begin
                     // Request stays up until the engine reports tx_abort_done or tx_done
                     s_nxt.abort_req[widx] = 1'b1;
                  end
               end
            end
         end
         s_nxt.bresp = whit ? BRESP_OKAY : BRESP_DECERR;
      end

      // Hardware sets come after software clears so a same-cycle event wins
      if (rx_store) begin
         if (s_r.full[rx_store_buf]) begin
            s_nxt.ovf[rx_store_buf] = 1'b1;
         end
         s_nxt.full[rx_store_buf] = 1'b1;
      end
      if (rx_remote && rx_remote_buf < 5'd8 && s_r.ctrl[rx_remote_buf[2:0]].rtr_en
          && s_r.ctrl[rx_remote_buf[2:0]].dir) begin
         s_nxt.ctrl[rx_remote_buf[2:0]].req = 1'b1;
         s_nxt.ctrl[rx_remote_buf[2:0]].aborted = 1'b0;
         s_nxt.ctrl[rx_remote_buf[2:0]].arb_lost = 1'b0;
         s_nxt.ctrl[rx_remote_buf[2:0]].bus_err = 1'b0;
      end

      // Pick highest priority; scanning upward with >= favours higher buffers
      s_nxt.pend = 1'b0;
      s_nxt.nbuf = '0;
      for (int i = 0; i < NUM_CTRL * 2; i++) begin
         if (s_r.ctrl[i].dir && s_r.ctrl[i].req && !s_r.abort_req[i] &&
             (!s_nxt.pend || {2'b00, s_r.ctrl[i].prio} >= best_pri)) begin
            s_nxt.pend = 1'b1;
            s_nxt.nbuf = 3'(i);
            best_pri = {2'b00, s_r.ctrl[i].prio};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.st <= BUS_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_bvalid  = (s_r.st == BUS_WRSP);
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_rvalid  = (s_r.st == BUS_RRSP);
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;
   assign filter_accept = s_r.acc;
   assign tx_pending    = s_r.pend;
   assign tx_next_buf   = s_r.nbuf;
   assign tx_abort_req  = s_r.abort_req;
   generate
      for (genvar g = 0; g < 8; g++) begin : g_dir
         assign buffer_direction_select[g] = s_r.ctrl[g].dir;
      end
   endgenerate
endmodule

// ---- can_mbs_monitor.sv ----
// Assertion checker for the CAN mask, buffer flag and transmit control block
`timescale 1ns/1ns
module can_mbs_monitor
   import can_mbs_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire can_id_t     frame_id,
   input wire can_id_t     filter_id,
   input wire logic [1:0]  filter_mask_source,
   input wire logic        filter_accept,
   input wire logic        tx_done,
   input wire logic        tx_abort_done,
   input wire logic [2:0]  tx_event_buf,
   input wire logic        tx_pending,
   input wire logic [2:0]  tx_next_buf,
   input wire logic [7:0]  tx_abort_req,
   input wire logic [7:0]  buffer_direction_select
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer missing");
   a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40
      |=> s_axi_rresp == BRESP_DECERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_nomask_match: assert property (filter_mask_source == NO_MASK_SEL
      && frame_id == filter_id |=> filter_accept) else $error("exact match refused");
   a_nomask_differ: assert property (filter_mask_source == NO_MASK_SEL && frame_id.ext
      && frame_id.eid != filter_id.eid |=> !filter_accept) else $error("mismatch accepted");
   a_abort_clears: assert property (tx_done || tx_abort_done
      |=> !tx_abort_req[$past(tx_event_buf)]) else $error("abort request stuck");
   // Direction may change under a pending request, so only a settled direction is judged
   a_pending_is_tx: assert property (tx_pending && $stable(buffer_direction_select)
      |-> buffer_direction_select[tx_next_buf]) else $error("receive buffer scheduled");
   c_accept: cover property (filter_accept);
   c_pending: cover property (tx_pending);
   c_abort: cover property (tx_abort_req != 8'h00);
endmodule
bind can_mbs can_mbs_monitor mon_inst (.*);

// ---- can_engine_model.sv ----
// Protocol engine stand-in that issues one-cycle receive and transmit events
`timescale 1ns/1ns
module can_engine_model (
   input  wire logic       aclk,
   input  wire logic       go,
   input  wire logic [2:0] kind,
   input  wire logic [4:0] which,
   output logic            rx_store,
   output logic [4:0]      rx_store_buf,
   output logic            rx_remote,
   output logic [4:0]      rx_remote_buf,
   output logic            tx_done,
   output logic            tx_abort_done,
   output logic            tx_arb_lost,
   output logic            tx_bus_error,
   output logic [2:0]      tx_event_buf
);
   initial begin
      {rx_store, rx_remote, tx_done, tx_abort_done, tx_arb_lost, tx_bus_error} = '0;
      {rx_store_buf, rx_remote_buf, tx_event_buf} = '0;
   end
   // Idle index lines flip every cycle so a stale buffer number does not hold steady
   always @(posedge aclk) begin
      rx_store <= go && kind == 3'h0;
      rx_remote <= go && kind == 3'h1;
      tx_done <= go && kind == 3'h2;
      tx_abort_done <= go && kind == 3'h3;
      tx_arb_lost <= go && kind == 3'h4;
      tx_bus_error <= go && kind == 3'h5;
      rx_store_buf <= go ? which : ~rx_store_buf;
      rx_remote_buf <= go ? which : ~rx_remote_buf;
      tx_event_buf <= go ? which[2:0] : ~tx_event_buf;
   end
endmodule

// ---- tb.sv ----
// Register and event level testbench for the CAN mask and buffer control block
`timescale 1ns/1ns
module tb
   import can_mbs_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, go;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, tx_abort_req, buffer_direction_select;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, filter_mask_source, rsp;
   can_id_t frame_id, filter_id;
   logic filter_accept, rx_store, rx_remote, tx_done, tx_abort_done, tx_arb_lost, tx_bus_error;
   logic [4:0] rx_store_buf, rx_remote_buf, which;
   logic [2:0] tx_event_buf, tx_next_buf, kind;
   logic tx_pending;
   int num_errors, samples_checked;
   can_mbs can_mbs_inst (.*);
   can_engine_model can_engine_model_inst (.*);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      int n;
      logic aw, w, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) break;
      end
      if (n == 20) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      logic ar, r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         rdv = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) break;
      end
      if (n == 20) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
      rd(a);
      chk(nm, rdv, {16'h0000, e});
   endtask
   task automatic ev(input logic [2:0] k, input logic [4:0] b);
      kind <= k;
      which <= b;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic acc(input logic [1:0] s, input can_id_t f, input can_id_t p, input logic e);
      filter_mask_source <= s;
      frame_id <= f;
      filter_id <= p;
      @(posedge aclk);
      @(negedge aclk);
      chk("accept", 32'(filter_accept), 32'(e));
      @(posedge aclk);
   endtask
   task automatic nx(input logic [3:0] e);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk("next buffer", 32'({tx_pending, tx_next_buf}), 32'(e));
      @(posedge aclk);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, go, kind, which} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, frame_id, filter_id, filter_mask_source} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
      num_errors = 0;
      samples_checked = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 32; a < 64; a += 4) rc("reset", 8'(a), 16'h0000);
      rd(8'h40);
      chk("unmapped read", {rsp, rdv[29:0]}, {BRESP_DECERR, 30'h0000_0000});
      wr(8'h40, 16'h1234);
      chk("unmapped write", 32'(rsp), 32'(BRESP_DECERR));
      for (int n = 0; n < 3; n++) begin
         wr(8'(8 * n), 16'hFFFF);
         wr(8'(8 * n + 4), 16'hFFFF);
         rc("mask std", 8'(8 * n), 16'hFFEB);
         rc("mask ext", 8'(8 * n + 4), 16'hFFFF);
      end
      wr(8'h08, 16'hFFE0);
      wr(8'h0C, 16'h0000);
      acc(2'b01, {1'b1, 11'h5A5, 18'h0_0000}, {1'b0, 11'h5A5, 18'h3_FFFF}, 1'b1);
      acc(2'b01, {1'b0, 11'h5A4, 18'h0_0000}, {1'b0, 11'h5A5, 18'h0_0000}, 1'b0);
      wr(8'h10, 16'h0008);
      acc(2'b10, {1'b1, 11'h001, 18'h0_0001}, {1'b0, 11'h7FE, 18'h0_0000}, 1'b0);
      acc(2'b10, {1'b0, 11'h001, 18'h0_0001}, {1'b0, 11'h7FE, 18'h0_0000}, 1'b1);
      acc(2'b10, {1'b1, 11'h001, 18'h3_0000}, {1'b1, 11'h7FE, 18'h0_0000}, 1'b1);
      acc(2'b10, {1'b1, 11'h001, 18'h0_0001}, {1'b1, 11'h7FE, 18'h0_0000}, 1'b0);
      wr(8'h00, 16'h000B);
      wr(8'h04, 16'h00FF);
      acc(2'b00, {1'b1, 11'h111, 18'h2_0000}, {1'b1, 11'h222, 18'h0_0000}, 1'b0);
      acc(2'b00, {1'b1, 11'h111, 18'h0_FF00}, {1'b1, 11'h222, 18'h0_0000}, 1'b1);
      acc(2'b11, {1'b1, 11'h111, 18'h0_0001}, {1'b1, 11'h111, 18'h0_0001}, 1'b1);
      acc(2'b11, {1'b1, 11'h111, 18'h0_0001}, {1'b1, 11'h111, 18'h0_0000}, 1'b0);
      ev(3'h0, 5'd3);
      ev(3'h0, 5'd20);
      rc("full low", FULL_LO_ADDR, 16'h0008);
      rc("full high", FULL_HI_ADDR, 16'h0010);
      rc("overflow low", OVF_LO_ADDR, 16'h0000);
      ev(3'h0, 5'd3);
      ev(3'h0, 5'd20);
      rc("overflow low", OVF_LO_ADDR, 16'h0008);
      rc("overflow high", OVF_HI_ADDR, 16'h0010);
      wr(FULL_LO_ADDR, 16'hFFFF);
      rc("full low", FULL_LO_ADDR, 16'h0008);
      wr(FULL_LO_ADDR, 16'hFFF7);
      rc("full low", FULL_LO_ADDR, 16'h0000);
      wr(OVF_HI_ADDR, 16'h0000);
      rc("overflow high", OVF_HI_ADDR, 16'h0000);
      wr(CTRL_BASE_ADDR, 16'h83F5);
      chk("write resp", 32'(rsp), 32'(BRESP_OKAY));
      rc("control", CTRL_BASE_ADDR, 16'h8385);
      wr(8'h3C, 16'h8000);
      rc("control", 8'h3C, 16'h8000);
      chk("direction", 32'(buffer_direction_select), 32'h0000_0083);
      ev(3'h1, 5'd1);
      rc("control", CTRL_BASE_ADDR, 16'h8385);
      ev(3'h1, 5'd0);
      rc("control", CTRL_BASE_ADDR, 16'h838D);
      nx(4'h8);
      wr(CTRL_BASE_ADDR, 16'h8B8D);
      nx(4'h9);
      wr(CTRL_BASE_ADDR, 16'h898D);
      nx(4'h9);
      wr(CTRL_BASE_ADDR, 16'h888D);
      nx(4'h8);
      ev(3'h2, 5'd0);
      rc("control", CTRL_BASE_ADDR, 16'h8885);
      nx(4'h9);
      wr(CTRL_BASE_ADDR, 16'h8085);
      chk("abort request", 32'(tx_abort_req), 32'h0000_0002);
      rc("control", CTRL_BASE_ADDR, 16'h8885);
      ev(3'h3, 5'd1);
      rc("control", CTRL_BASE_ADDR, 16'hC085);
      chk("abort request", 32'(tx_abort_req), 32'h0000_0000);
      ev(3'h4, 5'd1);
      ev(3'h5, 5'd1);
      rc("control", CTRL_BASE_ADDR, 16'hF085);
      wr(CTRL_BASE_ADDR, 16'h8885);
      rc("control", CTRL_BASE_ADDR, 16'h8885);
      summarize();
   end
endmodule
